//--- rtl/dtcp_regs.vh
`ifndef DTCP_REGS_VH
`define DTCP_REGS_VH
// Register byte addresses on APB
`define DTCP_NARROW_CTRL_ADDR   12'h000
`define DTCP_NARROW_COUNT_ADDR  12'h004
`define DTCP_WIDE_CTRL_ADDR     12'h008
`define DTCP_WIDE_CNT_LOW_ADDR  12'h00c
`define DTCP_WIDE_CNT_HIGH_ADDR 12'h010
`define DTCP_CMPA_LOW_ADDR      12'h014
`define DTCP_CMPA_HIGH_ADDR     12'h018
`define DTCP_CMPB_LOW_ADDR      12'h01c
`define DTCP_CMPB_HIGH_ADDR     12'h020
`define DTCP_CAPT_LOW_ADDR      12'h024
`define DTCP_CAPT_HIGH_ADDR     12'h028
`define DTCP_FLAG_ADDR          12'h02c
`define DTCP_MASK_ADDR          12'h030
// Field positions
`define DTCP_CTC_BIT            3
`define DTCP_PWM_BIT            4
`define DTCP_OVF0_BIT           1
// Clock select codes
`define DTCP_SEL_STOP           3'h0
`define DTCP_SEL_CK             3'h1
`define DTCP_SEL_DIV8           3'h2
`define DTCP_SEL_DIV64          3'h3
`define DTCP_SEL_DIV256         3'h4
`define DTCP_SEL_DIV1024        3'h5
`define DTCP_SEL_EXT_FALL       3'h6
`define DTCP_SEL_EXT_RISE       3'h7
// Prescaler tap bit positions
`define DTCP_TAP8               2
`define DTCP_TAP64              5
`define DTCP_TAP256             7
`define DTCP_TAP1024            9
`define DTCP_RESET_BYTE         8'h00
`endif

//--- rtl/dtcp_top.v
// Notes on behaviour
// (R1) One 8-bit and one 16-bit counter, each from internal timebase or pin.
// (R2) Both counters share one 10-bit prescaler with independent selections.
// (R3) Prescaler taps divide the oscillator clock by 8, 64, 256 and 1024.
// (R4) Each counter may also select undivided clock, external source or stop.
// (R5) External count input is synchronised on rising core clock edges.
// (R6) Pin driver keeps at least one core clock between transitions.
// (R7) Narrow overflow flag and enable sit in shared flag and mask registers.
// (R8) With clear-on-match-A set, wide counter clears the cycle after a match.
// (R9) With clear-on-match-A clear, wide counter ignores compare matches.
// (R10) Match detected one core cycle later, so prescaled clear timing differs.
// (R11) In PWM mode clear-on-match-A has no effect.
// (R12) Wide select: stop, CK, four taps, pin falling, pin rising.
// (R13) Pin transitions clock the wide counter even if pin is an output.
// (R14) Wide counter accesses pass through one shared byte latch.
// (R15) Same latch serves both compare registers and capture register.
// (R16) Software guards latch accesses against interrupts.
// (R17) Write high byte to latch first; low byte write commits sixteen bits.
// (R18) Low byte read latches high byte; high read returns latch.
// (R19) After a preset, counting resumes from written value next tick.
// (R20) Counters increment per active tick and hold while stopped.
// (R21) Narrow wrap sets overflow flag; masked request output raised.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "dtcp_regs.vh"
module dtcp_top #(
   parameter PRESCALE_W = 10
) (
   input  wire        SYS_CLK,
   input  wire        RESETN,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire        NARROW_EXT_PIN,
   input  wire        WIDE_COUNTER_EXT_PIN,
   input  wire        CAPTURE_STROBE,
   output wire        NARROW_OVF_IRQ,
   output wire        COMPARE_A_MATCH,
   output wire [15:0] WIDE_COUNTER_VALUE
);
   // Timer state and software-visible registers
   reg  [PRESCALE_W-1:0] prescale;
   reg  [PRESCALE_W-1:0] prescale_d;
   reg  [2:0]            narrow_counter_control;
   reg  [7:0]            narrow_count;
   reg  [7:0]            wide_ctrl;
   reg  [15:0]           wide_counter_value;
   reg  [15:0]           wide_compare_a;
   reg  [15:0]           wide_compare_b;
   reg  [15:0]           wide_capture_value;
   reg  [7:0]            byte_latch;
   reg  [7:0]            timer_flag_register;
   reg  [7:0]            timer_mask_register;
   reg                   match_a_d;
   // Pin synchroniser flops, two deep plus an edge history stage
   reg                   n_meta;
   reg                   n_sync;
   reg                   n_prev;
   reg                   w_meta;
   reg                   w_sync;
   reg                   w_prev;
   reg                   c_meta;
   reg                   c_sync;
   reg                   c_prev;
   // Decoded strobes and tick enables
   wire                  wr;
   wire                  rd;
   wire                  narrow_tick;
   wire                  wide_tick;
   wire                  narrow_wrap;
   wire                  match_a;
   wire                  clear_on_match_a;
   wire                  pwm_mode;
   wire                  capture_event;

   // Single-cycle APB slave, unmapped reads return zero
   // No wait states: every register answers in the access phase
   // Unmapped offsets are ignored rather than flagged as errors,
   // so software probing the map never sees a bus fault
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;
   assign wr      = PSEL & PENABLE & PWRITE;
   assign rd      = PSEL & PENABLE & ~PWRITE;

   // Control bit views and registered outputs
   assign clear_on_match_a   = wide_ctrl[`DTCP_CTC_BIT];
   assign pwm_mode           = wide_ctrl[`DTCP_PWM_BIT];
   assign WIDE_COUNTER_VALUE = wide_counter_value;
   assign COMPARE_A_MATCH    = match_a_d;
   // (R21) masked overflow request
   assign NARROW_OVF_IRQ     = timer_flag_register[`DTCP_OVF0_BIT] & timer_mask_register[`DTCP_OVF0_BIT];

   // (R2) (R3) shared free-running prescaler
   // All taps come from this one counter, so both timers stay in phase;
   // a tap switched mid-period may give one short first interval
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         prescale <= {PRESCALE_W{1'b0}};
      end else begin
         prescale <= prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      end
   end

   // Last prescaler value, for falling-bit tap detection
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         prescale_d <= {PRESCALE_W{1'b0}};
      end else begin
         prescale_d <= prescale;
      end
   end

   // (R5) narrow pin: two flops, then an edge history flop
   // Only the second and third flops feed logic; the first may be metastable
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         n_meta <= 1'b0;
         n_sync <= 1'b0;
         n_prev <= 1'b0;
      end else begin
         n_meta <= NARROW_EXT_PIN;
         n_sync <= n_meta;
         n_prev <= n_sync;
      end
   end

   // (R13) wide pin sampled alike, whatever its direction
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         w_meta <= 1'b0;
         w_sync <= 1'b0;
         w_prev <= 1'b0;
      end else begin
         w_meta <= WIDE_COUNTER_EXT_PIN;
         w_sync <= w_meta;
         w_prev <= w_sync;
      end
   end

   // Capture strobe; reset level 0 matches an idle low pin, so no false edge
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         c_meta <= 1'b0;
         c_sync <= 1'b0;
         c_prev <= 1'b0;
      end else begin
         c_meta <= CAPTURE_STROBE;
         c_sync <= c_meta;
         c_prev <= c_sync;
      end
   end

   // Rising edge of the synchronised strobe
   assign capture_event = c_sync & ~c_prev;

   // Tap enable: one pulse when a prescaler bit falls, i.e. every 2^(n+1) clocks
   // Pin modes use the synchronised level, so a pin count lags the pin
   // edge by three core cycles; pin levels held for less than one core cycle may be lost
   // Unused select codes fall to the stopped case
   function tick_of;
      input [2:0]            sel;
      input [PRESCALE_W-1:0] now;
      input [PRESCALE_W-1:0] was;
      input                  pin_now;
      input                  pin_was;
      begin
         case (sel)
            `DTCP_SEL_STOP:     tick_of = 1'b0;
            `DTCP_SEL_CK:       tick_of = 1'b1;
            `DTCP_SEL_DIV8:     tick_of = was[`DTCP_TAP8] & ~now[`DTCP_TAP8];
            `DTCP_SEL_DIV64:    tick_of = was[`DTCP_TAP64] & ~now[`DTCP_TAP64];
            `DTCP_SEL_DIV256:   tick_of = was[`DTCP_TAP256] & ~now[`DTCP_TAP256];
            `DTCP_SEL_DIV1024:  tick_of = was[`DTCP_TAP1024] & ~now[`DTCP_TAP1024];
            `DTCP_SEL_EXT_FALL: tick_of = pin_was & ~pin_now;
            `DTCP_SEL_EXT_RISE: tick_of = ~pin_was & pin_now;
            default:            tick_of = 1'b0;
         endcase
      end
   endfunction

   // (R3) (R4) per-counter source selection
   assign narrow_tick = tick_of(narrow_counter_control, prescale, prescale_d, n_sync, n_prev);
   // (R12) (R13) wide select, pin read regardless of direction
   assign wide_tick   = tick_of(wide_ctrl[2:0], prescale, prescale_d, w_sync, w_prev);
   assign narrow_wrap = narrow_tick & (narrow_count == 8'hff);
   // Compare only on counting, so a preset to the compare value matches on the next tick, not on the write
   assign match_a     = wide_tick & (wide_counter_value == wide_compare_a);

   // (R4) narrow source select register
   // Takes effect at once; a pending tap phase is not reset
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         narrow_counter_control <= 3'h0;
      end else if (wr && PADDR == `DTCP_NARROW_CTRL_ADDR) begin
         narrow_counter_control <= PWDATA[2:0];
      end
   end

   // (R1) (R20) narrow counter; software write wins over a tick
   // A write on a tick edge drops that tick rather than mixing values
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         narrow_count <= `DTCP_RESET_BYTE;
      end else if (wr && PADDR == `DTCP_NARROW_COUNT_ADDR) begin
         narrow_count <= PWDATA[7:0];
      end else if (narrow_tick) begin
         narrow_count <= narrow_count + 8'h01;
      end
   end

   // (R7) shared mask register
   // Only bit 1 drives a request; other bits are stored for software
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         timer_mask_register <= `DTCP_RESET_BYTE;
      end else if (wr && PADDR == `DTCP_MASK_ADDR) begin
         timer_mask_register <= PWDATA[7:0];
      end
   end

   // (R7) (R21) shared flag register; hardware set beats write-one clear
   // Losing a wrap that meets a clear would hide an overflow from software
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         timer_flag_register <= `DTCP_RESET_BYTE;
      end else if (narrow_wrap) begin
         timer_flag_register[`DTCP_OVF0_BIT] <= 1'b1;
      end else if (wr && PADDR == `DTCP_FLAG_ADDR && PWDATA[`DTCP_OVF0_BIT]) begin
         timer_flag_register[`DTCP_OVF0_BIT] <= 1'b0;
      end
   end

   // (R10) match seen one core cycle after the counting edge
   // The registered pulse keeps the clear one cycle behind the count
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         match_a_d <= 1'b0;
      end else begin
         match_a_d <= match_a;
      end
   end

   // Wide control register: select, clear-on-match-A, PWM mode
   // Upper bits are stored but have no function here
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wide_ctrl <= 8'h00;
      end else if (wr && PADDR == `DTCP_WIDE_CTRL_ADDR) begin
         wide_ctrl <= PWDATA[7:0];
      end
   end

   // (R15) (R17) (R18) one shared byte latch for all wide registers
   // High-byte writes park here; low-byte reads of count or capture
   // load it, so a later high read returns the same sample
   // Hazard: any other latch user in between spoils a pending pair
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         byte_latch <= 8'h00;
      end else if (wr && (PADDR == `DTCP_WIDE_CNT_HIGH_ADDR || PADDR == `DTCP_CMPA_HIGH_ADDR
                          || PADDR == `DTCP_CMPB_HIGH_ADDR || PADDR == `DTCP_CAPT_HIGH_ADDR)) begin
         byte_latch <= PWDATA[7:0];
      end else if (rd && PADDR == `DTCP_WIDE_CNT_LOW_ADDR) begin
         byte_latch <= wide_counter_value[15:8];
      end else if (rd && PADDR == `DTCP_CAPT_LOW_ADDR) begin
         byte_latch <= wide_capture_value[15:8];
      end
   end

   // (R14) (R17) low-byte compare writes commit sixteen bits at once
   // Compare B is only stored; no action hangs off it here
   // A lone low write uses whatever the latch last held
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wide_compare_a <= 16'h0000;
         wide_compare_b <= 16'h0000;
      end else begin
         if (wr && PADDR == `DTCP_CMPA_LOW_ADDR) begin
            wide_compare_a <= {byte_latch, PWDATA[7:0]};
         end
         if (wr && PADDR == `DTCP_CMPB_LOW_ADDR) begin
            wide_compare_b <= {byte_latch, PWDATA[7:0]};
         end
      end
   end

   // Capture copies the live count on a synchronised strobe edge
   // Software cannot write it; high-byte writes only load the latch
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wide_capture_value <= 16'h0000;
      end else if (capture_event) begin
         wide_capture_value <= wide_counter_value;
      end
   end

   // Wide counter: preset beats clear, clear beats counting
   // A preset on a match cycle wins, so software keeps control
   // The clear uses the delayed match, one core cycle after the tick
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wide_counter_value <= 16'h0000;
      end else if (wr && PADDR == `DTCP_WIDE_CNT_LOW_ADDR) begin
         // (R19) preset wins; next tick counts on from it
         wide_counter_value <= {byte_latch, PWDATA[7:0]};
      end else if (match_a_d && clear_on_match_a && !pwm_mode) begin
         // (R8) (R11) clear after compare A match, not in PWM
         wide_counter_value <= 16'h0000;
      end else if (wide_tick) begin
         // (R9) (R20) plain counting otherwise
         wide_counter_value <= wide_counter_value + 16'h0001;
      end
   end

   // Read mux, registered data is presented combinationally in access phase
   // High halves of count and capture come from the latch, so a
   // low-first read pair is coherent; compare highs read directly
   // Data stays zero outside a read so the bus idles quietly
   always @* begin
      PRDATA = 32'h0000_0000;
      if (rd) begin
         case (PADDR)
            `DTCP_NARROW_CTRL_ADDR:   PRDATA = {29'h0, narrow_counter_control};
            `DTCP_NARROW_COUNT_ADDR:  PRDATA = {24'h0, narrow_count};
            `DTCP_WIDE_CTRL_ADDR:     PRDATA = {24'h0, wide_ctrl};
            `DTCP_WIDE_CNT_LOW_ADDR:  PRDATA = {24'h0, wide_counter_value[7:0]};
            `DTCP_WIDE_CNT_HIGH_ADDR: PRDATA = {24'h0, byte_latch};
            `DTCP_CMPA_LOW_ADDR:      PRDATA = {24'h0, wide_compare_a[7:0]};
            `DTCP_CMPA_HIGH_ADDR:     PRDATA = {24'h0, wide_compare_a[15:8]};
            `DTCP_CMPB_LOW_ADDR:      PRDATA = {24'h0, wide_compare_b[7:0]};
            `DTCP_CMPB_HIGH_ADDR:     PRDATA = {24'h0, wide_compare_b[15:8]};
            `DTCP_CAPT_LOW_ADDR:      PRDATA = {24'h0, wide_capture_value[7:0]};
            `DTCP_CAPT_HIGH_ADDR:     PRDATA = {24'h0, byte_latch};
            `DTCP_FLAG_ADDR:          PRDATA = {24'h0, timer_flag_register};
            `DTCP_MASK_ADDR:          PRDATA = {24'h0, timer_mask_register};
            default:                  PRDATA = 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- verif/dtcp_assertions.sv
`timescale 1ns/1ps
module dtcp_assertions (
   input wire        SYS_CLK,
   input wire        RESETN,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire        NARROW_EXT_PIN,
   input wire        WIDE_COUNTER_EXT_PIN,
   input wire        CAPTURE_STROBE,
   input wire        NARROW_OVF_IRQ,
   input wire        COMPARE_A_MATCH,
   input wire [15:0] WIDE_COUNTER_VALUE
);
   // Completed transfers by kind
   wire       acc = PSEL && PENABLE && PREADY;
   wire       wr  = acc && PWRITE;
   wire       rdl = acc && !PWRITE && PADDR == 12'h00c;
   wire       rdh = acc && !PWRITE && PADDR == 12'h010;
   wire       wrl = wr && PADDR == 12'h00c;
   wire       wrh = wr && PADDR == 12'h010;
   reg  [7:0] hi_rd;
   reg  [7:0] hi_wr;
   reg  [4:0] ctrl;
   // Mirrors, since internal registers are not visible
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         hi_rd <= 8'h00;
         hi_wr <= 8'h00;
         ctrl <= 5'h00;
      end else begin
         if (rdl) hi_rd <= WIDE_COUNTER_VALUE[15:8];
         if (wrh) hi_wr <= PWDATA[7:0];
         if (wr && PADDR == 12'h008) ctrl <= PWDATA[4:0];
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   chk_ready_high: assert property (PREADY && !PSLVERR) else $error("ready or error wrong");
   chk_idle_rdata: assert property (!(acc && !PWRITE) |-> PRDATA == 32'h0) else $error("read data not idle");
   chk_count_step:
      assert property ($changed(WIDE_COUNTER_VALUE) && $past(RESETN) && !$past(wrl) |->
         (WIDE_COUNTER_VALUE == $past(WIDE_COUNTER_VALUE) + 16'h1) || (WIDE_COUNTER_VALUE == 16'h0))
         else $error("counter jumped");
   chk_irq_fall:
      assert property ($fell(NARROW_OVF_IRQ) && $past(RESETN) |->
         $past(wr && (PADDR == 12'h02c || PADDR == 12'h030))) else $error("irq dropped alone");
   chk_read_low:
      assert property (rdl |-> PRDATA[7:0] == WIDE_COUNTER_VALUE[7:0]) else $error("low read wrong");
   chk_read_latch:
      assert property (rdl ##3 rdh |-> PRDATA[7:0] == hi_rd) else $error("high read not latched");
   chk_write_commit:
      assert property (wrh ##3 wrl |=> WIDE_COUNTER_VALUE == {hi_wr, $past(PWDATA[7:0])})
         else $error("write not committed");
   chk_match_pulse:
      assert property (COMPARE_A_MATCH |=> !COMPARE_A_MATCH) else $error("match pulse too long");
   chk_match_clear:
      assert property (COMPARE_A_MATCH && ctrl[3] && !ctrl[4] && !wrl |=> WIDE_COUNTER_VALUE == 16'h0)
         else $error("no clear on match");
   chk_match_keep:
      assert property (COMPARE_A_MATCH && (!ctrl[3] || ctrl[4]) && ctrl[2:0] == 3'h1 && !wrl |=>
         WIDE_COUNTER_VALUE == $past(WIDE_COUNTER_VALUE) + 16'h1) else $error("match disturbed count");
   cover property (COMPARE_A_MATCH && ctrl[3]);
   cover property (NARROW_OVF_IRQ);
   cover property (rdl ##3 rdh);
endmodule
bind dtcp_top dtcp_assertions u_chk (.*);

//--- verif/dtcp_pin_drv.sv
`timescale 1ns/1ps
module dtcp_pin_drv (
   input  wire SYS_CLK,
   output reg  PIN
);
   initial PIN = 1'b0;
   // each level held at least two core cycles
   task automatic pulses(input int n, input int half);
      if (half < 2) half = 2;
      repeat (n) begin
         repeat (half) @(posedge SYS_CLK);
         PIN <= 1'b1;
         repeat (half) @(posedge SYS_CLK);
         PIN <= 1'b0;
      end
   endtask
endmodule

//--- verif/tb_dual_timer_counter_prescaler.sv
`timescale 1ns/1ps
module tb_dual_timer_counter_prescaler;
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        irq;
   logic        match;
   logic        npin;
   logic        wpin;
   logic        cpin;
   logic [15:0] cval;
   logic [31:0] rd;
   int          n_fail;
   int          n_compared;
   int          c;
   int          k;
   int          gap;
   int          exp_q[$];
   int          taps[5] = '{1, 8, 64, 256, 1024};
   int          modes[3] = '{9, 1, 25};
   dtcp_top u_dut (.SYS_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
      .NARROW_EXT_PIN(npin), .WIDE_COUNTER_EXT_PIN(wpin), .CAPTURE_STROBE(cpin),
      .NARROW_OVF_IRQ(irq), .COMPARE_A_MATCH(match), .WIDE_COUNTER_VALUE(cval));
   dtcp_pin_drv u_wpin (.SYS_CLK(clk), .PIN(wpin));
   dtcp_pin_drv u_npin (.SYS_CLK(clk), .PIN(npin));
   dtcp_pin_drv u_cpin (.SYS_CLK(clk), .PIN(cpin));
   // Core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, then an idle edge so no signal is set twice at once
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Cycles between two counter steps, sampled mid-cycle
   task automatic step_gap(output int n);
      logic [15:0] v;
      @(negedge clk);
      v = cval;
      n = 0;
      while (cval === v) @(negedge clk);
      v = cval;
      while (cval === v) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   // no interrupts here, so each latch pair runs uninterrupted
   task automatic preset(input int v);
      apb(12'h010, 1'b1, v >> 8);
      apb(12'h00c, 1'b1, v & 255);
   endtask
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog well beyond the longest scenario
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      n_fail = 0;
      n_compared = 0;
      rstn = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      void'($urandom(41));
      for (k = 0; k <= 'h34; k += 4) begin
         apb(k[11:0], 1'b0, 0);
         chk("reset read", 0, rd);
      end
      c = $urandom_range(65535, 0);
      preset(c);
      apb(12'h00c, 1'b0, 0);
      chk("count low", c & 255, rd);
      apb(12'h010, 1'b0, 0);
      chk("count high", c >> 8, rd);
      chk("held count", c, cval);
      c = $urandom_range(60, 8);
      apb(12'h018, 1'b1, 0);
      apb(12'h014, 1'b1, c);
      foreach (modes[i]) begin
         apb(12'h008, 1'b1, 0);
         preset(0);
         apb(12'h008, 1'b1, modes[i]);
         while (match !== 1'b1) @(negedge clk);
         chk("match count", c + 1, cval);
         @(negedge clk);
         chk("after match", modes[i] == 9 ? 0 : c + 2, cval);
      end
      foreach (taps[i]) begin
         apb(12'h008, 1'b1, i + 1);
         step_gap(gap);
         chk("tap gap", taps[i], gap);
      end
      apb(12'h008, 1'b1, 0);
      preset(0);
      apb(12'h008, 1'b1, 7);
      u_wpin.pulses(5, 2);
      repeat (6) @(posedge clk);
      chk("rise count", 5, cval);
      apb(12'h008, 1'b1, 6);
      u_wpin.pulses(3, 3);
      repeat (6) @(posedge clk);
      chk("fall count", 8, cval);
      // Capture the held count through the strobe pin
      u_cpin.pulses(1, 2);
      repeat (6) @(posedge clk);
      apb(12'h024, 1'b0, 0);
      chk("capture low", 8, rd);
      apb(12'h028, 1'b0, 0);
      chk("capture high", 0, rd);
      apb(12'h030, 1'b1, 2);
      apb(12'h004, 1'b1, 8'hf0);
      apb(12'h000, 1'b1, 1);
      repeat (20) @(posedge clk);
      chk("overflow irq", 1, irq);
      apb(12'h02c, 1'b0, 0);
      chk("flag", 2, rd);
      apb(12'h000, 1'b1, 0);
      apb(12'h02c, 1'b1, 2);
      chk("irq cleared", 0, irq);
      apb(12'h004, 1'b1, 0);
      apb(12'h000, 1'b1, 7);
      u_npin.pulses(4, 2);
      repeat (6) @(posedge clk);
      apb(12'h004, 1'b0, 0);
      chk("narrow pin count", 4, rd);
      // Compare B through the shared latch, expected bytes queued
      c = $urandom_range(65535, 0);
      apb(12'h020, 1'b1, c >> 8);
      apb(12'h01c, 1'b1, c & 255);
      exp_q.push_back(c & 255);
      exp_q.push_back(c >> 8);
      apb(12'h01c, 1'b0, 0);
      chk("compare b low", exp_q.pop_front(), rd);
      apb(12'h020, 1'b0, 0);
      chk("compare b high", exp_q.pop_front(), rd);
      results;
   end
endmodule
